// ---- shared/ufb_pkg.sv ----
package ufb_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_HOLD_EN = 8'h20;
  localparam logic [7:0] OFS_MASKS = 8'h24;
  localparam logic [7:0] OFS_SOF = 8'h28;
  localparam logic [7:0] OFS_PID = 8'h2c;
  localparam logic [7:0] OFS_ENDPOINT = 8'h30;
  localparam logic [7:0] OFS_EP_MARK = 8'h34;
  localparam logic [7:0] OFS_POWER = 8'h38;
  localparam logic [7:0] OFS_XCVR_CTRL = 8'h3c;
  localparam logic [7:0] OFS_FLAGS = 8'h40;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NUM_FLAGS = 7;
  localparam int MASK2_LSB = 8;
  localparam int MASK3_LSB = 16;
  localparam int SOF_HI_LSB = 8;
  localparam int EP_VALID_BIT = 4;
  localparam int PWR_VALID_BIT = 8;
  localparam int PD_OFF_BIT = 18;
  localparam int AUTO_SE0_BIT = 13;
  localparam int AUTO_K_BIT = 12;
  localparam int FILT_LSB = 8;
  localparam int HW_RESUME_BIT = 7;
  localparam int CONF_LSB = 4;

  // event flag bit numbers
  localparam int FLG_TOKEN = 6;
  localparam int FLG_SE0 = 5;
  localparam int FLG_K = 4;
  localparam int FLG_J = 3;
  localparam int FLG_CRC16 = 2;
  localparam int FLG_RXACT = 1;
  localparam int FLG_RXERR = 0;
  // flags that follow a level rather than latch an event
  localparam logic [6:0] LEVEL_FLAGS = 7'h3b;

  // interrupt status bits
  localparam int IRQ_BITS = 4;
  localparam int IRQ_AUTO_SE0 = 0;
  localparam int IRQ_AUTO_K = 1;
  localparam int IRQ_TOKEN = 2;
  localparam int IRQ_CRC16 = 3;

  // ----------------------------------------------------------------
  // line states and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
  localparam logic [15:0] FILT_CNT_RESET = 16'h0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

endpackage : ufb_pkg

// ---- core/ufb_flag_bank.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Functional notes
// ------------------------------------------------------------------
// Functional notes
// - seven hold-enable bits; a held flag keeps its value until written one.
// - a level flag not held simply follows later changes of its monitored signal.
// - first flag output is OR of flags selected by mask bits 6:0.
// - second flag output is OR of flags selected by mask bits 14:8.
// - third flag output is OR of flags selected by mask bits 22:16.
// - 11-bit frame counter, readable and writable, split 10:8 and 7:0.
// - last received packet identifier kept in bits 3:0, zero after reset.
// - last received endpoint in bits 3:0, bit 4 marks it valid.
// - marked endpoints go out on the receive port ORed with 0x10.
// - control bit 18 set turns off byte data port pulldowns.
// - automatic resume from SE0 sets bit 13 until software writes zero.
// - automatic resume from K sets bit 12 until software writes zero.
// - line-state changes pass after two to the power bits 11:8 clocks, plus one.
// - bit 7 lets hardware resume from suspend, else software polls filtered state.
// - transceiver config pins driven straight from control bits 6:4.
// - flag bits: token, SE0, K, J, CRC16 fail, receive active, receive error.
// - non-held event flags return to zero when the next packet begins.
module ufb_flag_bank #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic token_ok,
  input wire logic crc16_fail,
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic packet_start,
  input wire logic [1:0] line_state_raw,
  input wire logic suspended,
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame,
  input wire logic pid_valid,
  input wire logic [3:0] pid_in,
  input wire logic ep_valid_in,
  input wire logic [3:0] ep_in,
  output logic flag_output_first,
  output logic flag_output_second,
  output logic flag_output_third,
  output logic [4:0] rx_endpoint,
  output logic [1:0] line_state_filt,
  output logic resume_req,
  output logic byte_data_pulldown_off,
  output logic [2:0] transceiver_config_pins,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] hold_en;
    logic [6:0] mask1;
    logic [6:0] mask2;
    logic [6:0] mask3;
    logic [10:0] sof;
    logic [3:0] pid;
    logic [3:0] ep;
    logic ep_valid;
    logic [15:0] ep_mark;
    logic pwr_valid;
    logic [7:0] pwr_data;
    logic pd_off;
    logic auto_se0;
    logic auto_k;
    logic [3:0] filt_shift;
    logic hw_resume;
    logic [2:0] conf;
    logic [6:0] flags;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [1:0] ls_filt;
    logic [1:0] ls_cand;
    logic [15:0] ls_cnt;
    logic [31:0] rd_data;
    logic out1;
    logic out2;
    logic out3;
    logic irq;
    logic [4:0] rx_ep;
    logic resume_req;
  } ufb_state_t;

  ufb_state_t state_reg;
  ufb_state_t state_next;
  logic [6:0] monitor;
  logic [6:0] w1c;
  logic [15:0] filt_limit;
  logic [1:0] filt_now;
  logic [3:0] irq_events;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // one-cycle pulses
    state_next.resume_req = 1'b0;
    state_next.rd_data = ufb_pkg::REG_RESET;

    // register writes
    w1c = 7'h00;
    if (wr_en) begin
      case (addr[7:0])
        ufb_pkg::OFS_HOLD_EN: state_next.hold_en = wr_data[6:0];
        ufb_pkg::OFS_MASKS: begin
          state_next.mask1 = wr_data[6:0];
          state_next.mask2 = wr_data[ufb_pkg::MASK2_LSB +: 7];
          state_next.mask3 = wr_data[ufb_pkg::MASK3_LSB +: 7];
        end
        ufb_pkg::OFS_SOF: state_next.sof = wr_data[10:0];
        ufb_pkg::OFS_EP_MARK: state_next.ep_mark = wr_data[15:0];
        ufb_pkg::OFS_POWER: begin
          state_next.pwr_valid = wr_data[ufb_pkg::PWR_VALID_BIT];
          state_next.pwr_data = wr_data[7:0];
        end
        ufb_pkg::OFS_XCVR_CTRL: begin
          state_next.pd_off = wr_data[ufb_pkg::PD_OFF_BIT];
          state_next.auto_se0 = wr_data[ufb_pkg::AUTO_SE0_BIT];
          state_next.auto_k = wr_data[ufb_pkg::AUTO_K_BIT];
          state_next.filt_shift = wr_data[ufb_pkg::FILT_LSB +: 4];
          state_next.hw_resume = wr_data[ufb_pkg::HW_RESUME_BIT];
          state_next.conf = wr_data[ufb_pkg::CONF_LSB +: 3];
        end
        ufb_pkg::OFS_FLAGS: w1c = wr_data[6:0] & state_reg.hold_en;
        ufb_pkg::OFS_IRQ_STAT: state_next.irq_stat = state_reg.irq_stat & ~wr_data[3:0];
        ufb_pkg::OFS_IRQ_MASK: state_next.irq_mask = wr_data[3:0];
        default: begin
        end
      endcase
    end

    // line-state filter: a new value must stand 2^n + 1 clocks
    filt_limit = 16'h0001 << state_reg.filt_shift;
    filt_now = state_reg.ls_filt;
    if (line_state_raw != state_reg.ls_cand) begin
      state_next.ls_cand = line_state_raw;
      state_next.ls_cnt = ufb_pkg::FILT_CNT_RESET;
    end else if (line_state_raw != state_reg.ls_filt) begin
      if (state_reg.ls_cnt + 16'h0001 >= filt_limit) begin
        filt_now = line_state_raw;
        state_next.ls_cnt = ufb_pkg::FILT_CNT_RESET;
      end else begin
        state_next.ls_cnt = state_reg.ls_cnt + 16'h0001;
      end
    end
    state_next.ls_filt = filt_now;

    // hardware resume out of suspend
    if (state_reg.hw_resume && suspended) begin
      if (state_reg.ls_filt == ufb_pkg::LS_SE0) begin
        state_next.auto_se0 = 1'b1;
        state_next.irq_stat[ufb_pkg::IRQ_AUTO_SE0] = 1'b1;
        state_next.resume_req = 1'b1;
      end else if (state_reg.ls_filt == ufb_pkg::LS_K) begin
        state_next.auto_k = 1'b1;
        state_next.irq_stat[ufb_pkg::IRQ_AUTO_K] = 1'b1;
        state_next.resume_req = 1'b1;
      end
    end

    // event flags
    monitor = 7'h00;
    monitor[ufb_pkg::FLG_TOKEN] = token_ok;
    monitor[ufb_pkg::FLG_SE0] = filt_now == ufb_pkg::LS_SE0;
    monitor[ufb_pkg::FLG_K] = filt_now == ufb_pkg::LS_K;
    monitor[ufb_pkg::FLG_J] = filt_now == ufb_pkg::LS_J;
    monitor[ufb_pkg::FLG_CRC16] = crc16_fail;
    monitor[ufb_pkg::FLG_RXACT] = rx_active;
    monitor[ufb_pkg::FLG_RXERR] = rx_error;
    for (int i = 0; i < ufb_pkg::NUM_FLAGS; i++) begin
      if (monitor[i]) begin
        state_next.flags[i] = 1'b1;
      end else if (state_reg.hold_en[i]) begin
        if (w1c[i]) begin
          state_next.flags[i] = 1'b0;
        end
      end else if (ufb_pkg::LEVEL_FLAGS[i]) begin
        state_next.flags[i] = 1'b0;
      end else if (packet_start) begin
        state_next.flags[i] = 1'b0;
      end
    end

    // flag outputs follow the new flags in the same cycle
    state_next.out1 = |(state_next.flags & state_next.mask1);
    state_next.out2 = |(state_next.flags & state_next.mask2);
    state_next.out3 = |(state_next.flags & state_next.mask3);

    // capture from the packet machine
    if (sof_valid) begin
      state_next.sof = sof_frame;
    end
    if (pid_valid) begin
      state_next.pid = pid_in;
    end
    if (ep_valid_in) begin
      state_next.ep = ep_in;
      state_next.ep_valid = 1'b1;
      state_next.rx_ep = {state_reg.ep_mark[ep_in], ep_in};
    end

    // interrupts: set wins over clear
    irq_events = 4'h0;
    // auto-resume causes come from the resume logic, never from a write
    irq_events[ufb_pkg::IRQ_TOKEN] = token_ok;
    irq_events[ufb_pkg::IRQ_CRC16] = crc16_fail;
    state_next.irq_stat = state_next.irq_stat | irq_events;
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

    // read data, valid in the following cycle only
    if (rd_en) begin
      case (addr[7:0])
        ufb_pkg::OFS_HOLD_EN: state_next.rd_data = {25'h0, state_reg.hold_en};
        ufb_pkg::OFS_MASKS: state_next.rd_data = {9'h0, state_reg.mask3, 1'b0,
                                                  state_reg.mask2, 1'b0, state_reg.mask1};
        ufb_pkg::OFS_SOF: state_next.rd_data = {21'h0, state_reg.sof};
        ufb_pkg::OFS_PID: state_next.rd_data = {28'h0, state_reg.pid};
        ufb_pkg::OFS_ENDPOINT: state_next.rd_data = {27'h0, state_reg.ep_valid, state_reg.ep};
        ufb_pkg::OFS_EP_MARK: state_next.rd_data = {16'h0, state_reg.ep_mark};
        ufb_pkg::OFS_POWER: state_next.rd_data = {23'h0, state_reg.pwr_valid,
                                                  state_reg.pwr_data};
        ufb_pkg::OFS_XCVR_CTRL: state_next.rd_data = {13'h0, state_reg.pd_off, 4'h0,
                                                      state_reg.auto_se0, state_reg.auto_k,
                                                      state_reg.filt_shift,
                                                      state_reg.hw_resume, state_reg.conf,
                                                      4'h0};
        ufb_pkg::OFS_FLAGS: state_next.rd_data = {25'h0, state_reg.flags};
        ufb_pkg::OFS_IRQ_STAT: state_next.rd_data = {28'h0, state_reg.irq_stat};
        ufb_pkg::OFS_IRQ_MASK: state_next.rd_data = {28'h0, state_reg.irq_mask};
        default: state_next.rd_data = ufb_pkg::REG_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rd_data;
  assign flag_output_first = state_reg.out1;
  assign flag_output_second = state_reg.out2;
  assign flag_output_third = state_reg.out3;
  assign rx_endpoint = state_reg.rx_ep;
  assign line_state_filt = state_reg.ls_filt;
  assign resume_req = state_reg.resume_req;
  assign byte_data_pulldown_off = state_reg.pd_off;
  assign transceiver_config_pins = state_reg.conf;
  assign irq = state_reg.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence crc_flag_clear_s;
    wr_en && addr[7:0] == ufb_pkg::OFS_FLAGS && wr_data[ufb_pkg::FLG_CRC16];
  endsequence

  sequence raw_fresh_s;
    state_reg.filt_shift == 4'h0 && line_state_raw != state_reg.ls_cand;
  endsequence

  sticky_hold_a: assert property (
    state_reg.hold_en[6] && state_reg.flags[6]
    && !(wr_en && addr[7:0] == ufb_pkg::OFS_FLAGS && wr_data[6]) |=> state_reg.flags[6])
    else $error("held flag lost its value");
  sticky_clear_a: assert property (
    (state_reg.hold_en[ufb_pkg::FLG_CRC16] && !crc16_fail) ##0 crc_flag_clear_s
    |=> !state_reg.flags[ufb_pkg::FLG_CRC16])
    else $error("held flag not cleared by write one");
  level_follow_a: assert property (
    !state_reg.hold_en[1] |=> state_reg.flags[1] == $past(rx_active))
    else $error("free flag did not follow receive active");
  first_out_a: assert property (
    flag_output_first == |(state_reg.flags & state_reg.mask1))
    else $error("first flag output wrong");
  second_out_a: assert property (
    flag_output_second == |(state_reg.flags & state_reg.mask2))
    else $error("second flag output wrong");
  third_out_a: assert property (
    flag_output_third == |(state_reg.flags & state_reg.mask3))
    else $error("third flag output wrong");
  pid_capture_a: assert property (
    pid_valid |=> state_reg.pid == $past(pid_in))
    else $error("packet identifier not captured");
  ep_mark_a: assert property (
    ep_valid_in |=> rx_endpoint == {$past(state_reg.ep_mark[ep_in]), $past(ep_in)}
                    && state_reg.ep_valid)
    else $error("endpoint marking wrong");
  pulldown_ctl_a: assert property (
    wr_en && addr[7:0] == ufb_pkg::OFS_XCVR_CTRL
    |=> byte_data_pulldown_off == $past(wr_data[ufb_pkg::PD_OFF_BIT]))
    else $error("pulldown control not taken");
  line_filter_a: assert property (
    raw_fresh_s ##1 ($stable(line_state_raw) && state_reg.filt_shift == 4'h0)
    |=> line_state_filt == $past(line_state_raw))
    else $error("line-state filter delay wrong");
  resume_k_a: assert property (
    state_reg.hw_resume && suspended && state_reg.ls_filt == ufb_pkg::LS_K
    |=> state_reg.auto_k && resume_req)
    else $error("K resume not recorded");
  resume_se0_a: assert property (
    state_reg.hw_resume && suspended && state_reg.ls_filt == ufb_pkg::LS_SE0
    |=> state_reg.auto_se0 ##1 state_reg.auto_se0 || $past(wr_en))
    else $error("SE0 resume not recorded");
  conf_pins_a: assert property (
    wr_en && addr[7:0] == ufb_pkg::OFS_XCVR_CTRL
    |=> transceiver_config_pins == $past(wr_data[6:4]))
    else $error("config pins not driven from control");
  sof_load_a: assert property (
    sof_valid |=> state_reg.sof == $past(sof_frame))
    else $error("frame counter not loaded");
  ep_capture_a: assert property (
    ep_valid_in |=> state_reg.ep == $past(ep_in) && state_reg.ep_valid)
    else $error("endpoint not captured");
  token_set_a: assert property (
    token_ok |=> state_reg.flags[ufb_pkg::FLG_TOKEN])
    else $error("token flag not set");
  crc_set_a: assert property (
    crc16_fail |=> state_reg.flags[ufb_pkg::FLG_CRC16])
    else $error("crc flag not set");
  event_clear_a: assert property (
    packet_start && !state_reg.hold_en[ufb_pkg::FLG_TOKEN] && !token_ok
    |=> !state_reg.flags[ufb_pkg::FLG_TOKEN])
    else $error("free event flag survived packet start");
  free_flag_keep_a: assert property (
    wr_en && addr[7:0] == ufb_pkg::OFS_FLAGS && !state_reg.hold_en[ufb_pkg::FLG_TOKEN]
    && state_reg.flags[ufb_pkg::FLG_TOKEN] && !packet_start
    |=> state_reg.flags[ufb_pkg::FLG_TOKEN])
    else $error("write one cleared a free flag");
  k_flag_follow_a: assert property (
    !state_reg.hold_en[ufb_pkg::FLG_K]
    |=> state_reg.flags[ufb_pkg::FLG_K] == (line_state_filt == ufb_pkg::LS_K))
    else $error("K flag does not follow filtered line");
  se0_flag_follow_a: assert property (
    !state_reg.hold_en[ufb_pkg::FLG_SE0]
    |=> state_reg.flags[ufb_pkg::FLG_SE0] == (line_state_filt == ufb_pkg::LS_SE0))
    else $error("SE0 flag does not follow filtered line");
  j_flag_follow_a: assert property (
    !state_reg.hold_en[ufb_pkg::FLG_J]
    |=> state_reg.flags[ufb_pkg::FLG_J] == (line_state_filt == ufb_pkg::LS_J))
    else $error("J flag does not follow filtered line");
  error_follow_a: assert property (
    !state_reg.hold_en[ufb_pkg::FLG_RXERR]
    |=> state_reg.flags[ufb_pkg::FLG_RXERR] == $past(rx_error))
    else $error("free flag did not follow receive error");
  resume_cause_a: assert property (
    resume_req |-> $past(state_reg.hw_resume) && $past(suspended))
    else $error("resume request without hardware resume");
  pulldown_keep_a: assert property (
    !(wr_en && addr[7:0] == ufb_pkg::OFS_XCVR_CTRL) |=> $stable(byte_data_pulldown_off))
    else $error("pulldown control changed without a write");
  conf_keep_a: assert property (
    !(wr_en && addr[7:0] == ufb_pkg::OFS_XCVR_CTRL) |=> $stable(transceiver_config_pins))
    else $error("config pins changed without a write");

endmodule : ufb_flag_bank

// ---- sim/ufb_phy_model.sv ----
`timescale 1ns/1ps

// ------
// transceiver and packet decoder side
// ------
module ufb_phy_model (
  input wire logic clock,
  output logic token_ok,
  output logic crc16_fail,
  output logic rx_active,
  output logic rx_error,
  output logic packet_start,
  output logic [1:0] line_state_raw,
  output logic suspended,
  output logic sof_valid,
  output logic [10:0] sof_frame,
  output logic pid_valid,
  output logic [3:0] pid_in,
  output logic ep_valid_in,
  output logic [3:0] ep_in
);
  initial begin
    {token_ok, crc16_fail, rx_active, rx_error, packet_start} = 5'h00;
    {suspended, sof_valid, pid_valid, ep_valid_in} = 4'h0;
    line_state_raw = ufb_pkg::LS_J;
    sof_frame = 11'h000;
    pid_in = 4'h0;
    ep_in = 4'h0;
  end
  task start_packet;
    @(posedge clock);
    packet_start <= 1'b1;
    @(posedge clock);
    packet_start <= 1'b0;
  endtask : start_packet
  task send_packet(input logic [3:0] pid, input logic [3:0] ep, input logic tok,
    input logic crc);
    start_packet();
    {pid_valid, ep_valid_in, token_ok, crc16_fail} <= {2'h3, tok, crc};
    pid_in <= pid;
    ep_in <= ep;
    @(posedge clock);
    {pid_valid, ep_valid_in, token_ok, crc16_fail} <= 4'h0;
    // fields are not held past their strobe
    pid_in <= ~pid;
    ep_in <= ~ep;
  endtask : send_packet
  task load_sof(input logic [10:0] f);
    @(posedge clock);
    sof_valid <= 1'b1;
    sof_frame <= f;
    @(posedge clock);
    sof_valid <= 1'b0;
    sof_frame <= ~f;
  endtask : load_sof
  task line(input logic [1:0] ls);
    @(posedge clock);
    line_state_raw <= ls;
  endtask : line
  task set_rx(input logic act, input logic err);
    @(posedge clock);
    rx_active <= act;
    rx_error <= err;
  endtask : set_rx
  task set_susp(input logic s);
    @(posedge clock);
    suspended <= s;
  endtask : set_susp
endmodule : ufb_phy_model

// ---- sim/usb_interface_flag_status_bank_tb_top.sv ----
`timescale 1ns/1ps

// ------
// bench
// ------
module usb_interface_flag_status_bank_tb_top;
  logic clock;
  logic nrst;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic token_ok, crc16_fail, rx_active, rx_error, packet_start;
  logic suspended, sof_valid, pid_valid, ep_valid_in, resume_req, irq;
  logic flag_output_first, flag_output_second, flag_output_third;
  logic byte_data_pulldown_off;
  logic [1:0] line_state_raw;
  logic [1:0] line_state_filt;
  logic [10:0] sof_frame;
  logic [3:0] pid_in;
  logic [3:0] ep_in;
  logic [4:0] rx_endpoint;
  logic [2:0] transceiver_config_pins;
  int failures;
  int n_checks;
  int n_resume;
  logic [7:0] ofs_tab [9] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h48};
  logic [31:0] exp_tab [9] = '{32'h7f, 32'h7f7f7f, 32'h7ff, 32'h0, 32'h0, 32'hffff, 32'h1ff,
    32'h43ff0, 32'hf};

  ufb_flag_bank dut (.clock, .nrst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .token_ok,
    .crc16_fail, .rx_active, .rx_error, .packet_start, .line_state_raw, .suspended,
    .sof_valid, .sof_frame, .pid_valid, .pid_in, .ep_valid_in, .ep_in, .flag_output_first,
    .flag_output_second, .flag_output_third, .rx_endpoint, .line_state_filt, .resume_req,
    .byte_data_pulldown_off, .transceiver_config_pins, .irq);
  ufb_phy_model phy (.clock, .token_ok, .crc16_fail, .rx_active, .rx_error, .packet_start,
    .line_state_raw, .suspended, .sof_valid, .sof_frame, .pid_valid, .pid_in, .ep_valid_in,
    .ep_in);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (resume_req === 1'b1) n_resume++;
  end

  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task chk_pin(input string name, input logic [31:0] exp, input logic [31:0] got);
    #1;
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : chk_pin
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 got = rd_data;
    chk_pin($sformatf("reg %h", a), exp, got);
  endtask : chk_reg
  task edges(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : edges

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    failures = 0;
    n_checks = 0;
    n_resume = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    // reset values, unmapped 0x4c included
    for (int i = 0; i < 12; i++) begin
      if (i != 8) chk_reg(8'h20 + 8'(4 * i), 32'h0);
    end
    for (int i = 0; i < 9; i++) begin
      wr(ofs_tab[i], 32'hffffffff);
      chk_reg(ofs_tab[i], exp_tab[i]);
    end
    chk_pin("pulldown", 1'h1, byte_data_pulldown_off);
    chk_pin("conf", 3'h7, transceiver_config_pins);
    for (int i = 0; i < 9; i++) wr(ofs_tab[i], 32'h0);
    chk_pin("pulldown", 1'h0, byte_data_pulldown_off);
    chk_pin("conf", 3'h0, transceiver_config_pins);
    // free flags, capture and interrupt
    wr(8'h24, 32'h20440);
    wr(8'h48, 32'h4);
    phy.send_packet(4'h9, 4'h3, 1'h1, 1'h0);
    #1;
    chk_pin("first", 1'h1, flag_output_first);
    edges(1);
    chk_pin("irq", 1'h1, irq);
    chk_reg(8'h2c, 32'h9);
    chk_reg(8'h30, 32'h13);
    chk_pin("rxep", 5'h03, rx_endpoint);
    chk_reg(8'h44, 32'h4);
    wr(8'h44, 32'h4);
    edges(2);
    chk_pin("irq", 1'h0, irq);
    phy.start_packet();
    #1;
    chk_pin("first", 1'h0, flag_output_first);
    // held flags
    wr(8'h20, 32'h44);
    phy.send_packet(4'h2, 4'h5, 1'h1, 1'h1);
    phy.start_packet();
    chk_pin("first", 1'h1, flag_output_first);
    chk_pin("second", 1'h1, flag_output_second);
    wr(8'h40, 32'h4);
    chk_pin("second", 1'h0, flag_output_second);
    wr(8'h20, 32'h0);
    wr(8'h40, 32'h40);
    chk_reg(8'h40, 32'h48);
    phy.start_packet();
    #1;
    chk_pin("first", 1'h0, flag_output_first);
    // level flags
    phy.set_rx(1'h1, 1'h0);
    edges(1);
    chk_pin("third", 1'h1, flag_output_third);
    chk_reg(8'h40, 32'ha);
    phy.set_rx(1'h0, 1'h1);
    edges(1);
    chk_pin("third", 1'h0, flag_output_third);
    chk_reg(8'h40, 32'h9);
    // frame counter and marked endpoint
    phy.load_sof(11'h5a3);
    chk_reg(8'h28, 32'h5a3);
    wr(8'h34, 32'h20);
    phy.send_packet(4'h1, 4'h5, 1'h0, 1'h0);
    edges(1);
    chk_pin("rxep", 5'h15, rx_endpoint);
    chk_reg(8'h30, 32'h15);
    // line filter, five clocks
    wr(8'h3c, 32'h200);
    phy.line(ufb_pkg::LS_K);
    edges(4);
    chk_pin("filt", ufb_pkg::LS_J, line_state_filt);
    edges(1);
    chk_pin("filt", ufb_pkg::LS_K, line_state_filt);
    chk_reg(8'h40, 32'h11);
    // hardware resume
    wr(8'h3c, 32'h80);
    phy.set_susp(1'h1);
    edges(3);
    chk_reg(8'h3c, 32'h1080);
    chk_pin("resume", 1'h1, n_resume != 0);
    phy.set_susp(1'h0);
    wr(8'h3c, 32'h80);
    chk_reg(8'h3c, 32'h80);
    phy.line(ufb_pkg::LS_SE0);
    edges(4);
    phy.set_susp(1'h1);
    edges(3);
    chk_reg(8'h3c, 32'h2080);
    phy.set_susp(1'h0);
    chk_reg(8'h44, 32'hf);
    chk_pin("irq", 1'h1, irq);
    wr(8'h48, 32'h0);
    edges(2);
    chk_pin("irq", 1'h0, irq);
    wr(8'h44, 32'hf);
    chk_reg(8'h44, 32'h0);
    stop_test();
  end
endmodule : usb_interface_flag_status_bank_tb_top
